// >>> rtl/mmfid_regs.v
// Memory-model feature identification registers with coprocessor access
//
// Behaviour
// [RULE1] All three registers read-only, privileged only; writes change nothing.
// [RULE2] First register reads zero in every field.
// [RULE3] First register answers opcode1 0, c0, c1, opcode2 5.
// [RULE4] Second register bits 27:24 read 0x1, wait-for-interrupt stalling.
// [RULE5] Second register bits 23:20 read 0x2, three barrier operations.
// [RULE6] Second register bits 31:28 and 19:0 read zero.
// [RULE7] Second register answers opcode1 0, c0, c1, opcode2 6.
// [RULE8] Third register bits 31:16 read zero, region protection scheme.
// [RULE9] Third register bits 15:12 read zero, maintenance stays local.
// [RULE10] Third register bits 11:8 read 0x2, branch predictor invalidates.
// [RULE11] Both branch predictor invalidates complete as no-operations.
// [RULE12] Third register bits 7:4 read 0x1, set and way operations.
// [RULE13] Third register bits 3:0 read 0x1, by-address operations.
// [RULE14] Third register answers opcode1 0, c0, c1, opcode2 7.
// [RULE15] Unprivileged access raises undefined-instruction, no data returned.
// [RULE16] Constant contents valid from reset; fixed latency, no side effects.
`timescale 1ns/10ps
`include "mmfid_defines.vh"

module mmfid_regs (
  // Clock and reset
  input wire CLOCK_IN,
  input wire SYS_RST_IN,
  // Coprocessor request
  input wire REQ_VALID_IN,
  input wire REQ_WRITE_IN,
  input wire REQ_PRIV_IN,
  input wire [2:0] REQ_OPC1_IN,
  input wire [3:0] REQ_CRN_IN,
  input wire [3:0] REQ_CRM_IN,
  input wire [2:0] REQ_OPC2_IN,
  // Response
  output reg RESP_DONE_OUT,
  output reg RESP_UNDEF_OUT,
  output reg [`MMFID_DATA_W-1:0] RESP_RDATA_OUT,
  output reg BP_INV_DONE_OUT
);

  // ==========================================================
  // Constant register contents
  wire [`MMFID_DATA_W-1:0] id_value [0:`MMFID_NUM_ID-1];
  wire [`MMFID_DATA_W-1:0] id_term [0:`MMFID_NUM_ID-1];
  wire [`MMFID_DATA_W-1:0] id_mux [0:`MMFID_NUM_ID];

  // [RULE2] all fields zero
  assign id_value[0] = {`MMFID_ONE_BP_REQ, `MMFID_ONE_TEST_CLEAN,
                        `MMFID_ONE_CACHE_UNI, `MMFID_ONE_CACHE_HAR,
                        `MMFID_ONE_SETWAY_UNI, `MMFID_ONE_SETWAY_HAR,
                        `MMFID_ONE_ADDR_UNI, `MMFID_ONE_ADDR_HAR};
  // [RULE4] [RULE5] [RULE6] wait, barrier, zero fields
  assign id_value[1] = {`MMFID_TWO_HW_ACCESS, `MMFID_TWO_WAIT_INT,
                        `MMFID_TWO_BARRIER, `MMFID_TWO_TLB_UNI,
                        `MMFID_TWO_TLB_HAR, `MMFID_TWO_RANGE,
                        `MMFID_TWO_BG_PREFETCH, `MMFID_TWO_FG_PREFETCH};
  // [RULE8] [RULE9] [RULE10] [RULE12] [RULE13] third layout
  assign id_value[2] = {`MMFID_THREE_SUPERSECT, `MMFID_THREE_SBZ_HI,
                        `MMFID_THREE_COHERENT, `MMFID_THREE_SBZ_LO,
                        `MMFID_THREE_BROADCAST, `MMFID_THREE_BP_MAINT,
                        `MMFID_THREE_SETWAY, `MMFID_THREE_BY_ADDR};

  // ==========================================================
  // Decode
  wire [`MMFID_SEL_W-1:0] sel;

  mmfid_decode u_decode (
    .opc1_in(REQ_OPC1_IN),
    .crn_in(REQ_CRN_IN),
    .crm_in(REQ_CRM_IN),
    .opc2_in(REQ_OPC2_IN),
    .sel_out(sel)
  );

  // ==========================================================
  // Read data selection
  assign id_mux[0] = `MMFID_DATA_ZERO;

  genvar i;
  generate
    for (i = 0; i < `MMFID_NUM_ID; i = i + 1) begin : g_id
      assign id_term[i] = {`MMFID_DATA_W{sel[i]}} & id_value[i];
      assign id_mux[i+1] = id_mux[i] | id_term[i];
    end
  endgenerate

  // ==========================================================
  // Access check
  wire id_hit;
  wire bp_hit;
  wire claim;
  wire legal_read;
  wire legal_bp;
  wire next_done;
  wire next_undef;
  wire next_bp_done;
  wire [`MMFID_DATA_W-1:0] next_rdata;

  assign id_hit = sel[`MMFID_SEL_ONE] | sel[`MMFID_SEL_TWO] | sel[`MMFID_SEL_THREE];
  assign bp_hit = sel[`MMFID_SEL_BP_ALL] | sel[`MMFID_SEL_BP_ADDR];
  // Encodings outside this bank are left to other banks: no answer here
  assign claim = REQ_VALID_IN & (id_hit | bp_hit);
  // [RULE1] reads only, privileged only
  assign legal_read = claim & REQ_PRIV_IN & ~REQ_WRITE_IN & id_hit;
  // [RULE11] invalidates accepted as writes
  assign legal_bp = claim & REQ_PRIV_IN & REQ_WRITE_IN & bp_hit;
  assign next_done = legal_read | legal_bp;
  // [RULE15] refuse unprivileged or misdirected
  assign next_undef = claim & ~next_done;
  // [RULE11] nothing touched, just completion
  assign next_bp_done = legal_bp;
  // [RULE15] data withheld unless legal read
  assign next_rdata = legal_read ? id_mux[`MMFID_NUM_ID] : `MMFID_DATA_ZERO;

  // ==========================================================
  // Response stage
  // [RULE16] one-cycle fixed latency
  always @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      RESP_DONE_OUT <= 1'b0;
      RESP_UNDEF_OUT <= 1'b0;
      RESP_RDATA_OUT <= `MMFID_DATA_ZERO;
      BP_INV_DONE_OUT <= 1'b0;
    end else begin
      RESP_DONE_OUT <= next_done;
      RESP_UNDEF_OUT <= next_undef;
      RESP_RDATA_OUT <= next_rdata;
      BP_INV_DONE_OUT <= next_bp_done;
    end
  end

endmodule // mmfid_regs

// >>> rtl/mmfid_defines.vh
// Constants for the memory-model feature identification register bank
`ifndef MMFID_DEFINES_VH
`define MMFID_DEFINES_VH

// ==========================================================
// Coprocessor operand encodings
`define MMFID_OPC1_ID 3'h0
`define MMFID_CRN_ID 4'h0
`define MMFID_CRM_ID 4'h1
`define MMFID_OPC2_ONE 3'h5
`define MMFID_OPC2_TWO 3'h6
`define MMFID_OPC2_THREE 3'h7
`define MMFID_OPC1_BP 3'h0
`define MMFID_CRN_BP 4'h7
`define MMFID_CRM_BP 4'h5
`define MMFID_OPC2_BP_ALL 3'h6
`define MMFID_OPC2_BP_ADDR 3'h7

// ==========================================================
// One-hot select positions
`define MMFID_SEL_W 5
`define MMFID_SEL_ONE 0
`define MMFID_SEL_TWO 1
`define MMFID_SEL_THREE 2
`define MMFID_SEL_BP_ALL 3
`define MMFID_SEL_BP_ADDR 4
`define MMFID_NUM_ID 3

// ==========================================================
// Widths and reset values
`define MMFID_DATA_W 32
`define MMFID_DATA_ZERO 32'h00000000
`define MMFID_SEL_NONE 5'h00

// ==========================================================
// memory_model_features_one fields, [31:28] down to [3:0]
`define MMFID_ONE_BP_REQ 4'h0
`define MMFID_ONE_TEST_CLEAN 4'h0
`define MMFID_ONE_CACHE_UNI 4'h0
`define MMFID_ONE_CACHE_HAR 4'h0
`define MMFID_ONE_SETWAY_UNI 4'h0
`define MMFID_ONE_SETWAY_HAR 4'h0
`define MMFID_ONE_ADDR_UNI 4'h0
`define MMFID_ONE_ADDR_HAR 4'h0

// ==========================================================
// memory_model_features_two fields, [31:28] down to [3:0]
`define MMFID_TWO_HW_ACCESS 4'h0
`define MMFID_TWO_WAIT_INT 4'h1
`define MMFID_TWO_BARRIER 4'h2
`define MMFID_TWO_TLB_UNI 4'h0
`define MMFID_TWO_TLB_HAR 4'h0
`define MMFID_TWO_RANGE 4'h0
`define MMFID_TWO_BG_PREFETCH 4'h0
`define MMFID_TWO_FG_PREFETCH 4'h0

// ==========================================================
// memory_model_features_three fields, [31:28] down to [3:0]
`define MMFID_THREE_SUPERSECT 4'h0
`define MMFID_THREE_SBZ_HI 4'h0
`define MMFID_THREE_COHERENT 4'h0
`define MMFID_THREE_SBZ_LO 4'h0
`define MMFID_THREE_BROADCAST 4'h0
`define MMFID_THREE_BP_MAINT 4'h2
`define MMFID_THREE_SETWAY 4'h1
`define MMFID_THREE_BY_ADDR 4'h1

`endif

// >>> rtl/mmfid_decode.v
// Operand decoder for the feature identification bank
`timescale 1ns/10ps
`include "mmfid_defines.vh"

module mmfid_decode (
  // Operand fields
  input wire [2:0] opc1_in,
  input wire [3:0] crn_in,
  input wire [3:0] crm_in,
  input wire [2:0] opc2_in,
  // One-hot select
  output reg [`MMFID_SEL_W-1:0] sel_out
);

  wire id_group;
  wire bp_group;

  assign id_group = (opc1_in == `MMFID_OPC1_ID) && (crn_in == `MMFID_CRN_ID) &&
                    (crm_in == `MMFID_CRM_ID);
  assign bp_group = (opc1_in == `MMFID_OPC1_BP) && (crn_in == `MMFID_CRN_BP) &&
                    (crm_in == `MMFID_CRM_BP);

  // ==========================================================
  // Select decode
  always @* begin
    sel_out = `MMFID_SEL_NONE;
    // [RULE3] first register encoding
    sel_out[`MMFID_SEL_ONE] = id_group && (opc2_in == `MMFID_OPC2_ONE);
    // [RULE7] second register encoding
    sel_out[`MMFID_SEL_TWO] = id_group && (opc2_in == `MMFID_OPC2_TWO);
    // [RULE14] third register encoding
    sel_out[`MMFID_SEL_THREE] = id_group && (opc2_in == `MMFID_OPC2_THREE);
    sel_out[`MMFID_SEL_BP_ALL] = bp_group && (opc2_in == `MMFID_OPC2_BP_ALL);
    sel_out[`MMFID_SEL_BP_ADDR] = bp_group && (opc2_in == `MMFID_OPC2_BP_ADDR);
  end

endmodule // mmfid_decode

// >>> verif/mmfid_regs_chk.sv
// Assertion checker for the feature identification bank ports
`timescale 1ns/10ps
module mmfid_regs_chk (
  // Clock, reset and request
  input wire CLOCK_IN,
  input wire SYS_RST_IN,
  input wire REQ_VALID_IN,
  input wire REQ_WRITE_IN,
  input wire REQ_PRIV_IN,
  input wire [2:0] REQ_OPC1_IN,
  input wire [3:0] REQ_CRN_IN,
  input wire [3:0] REQ_CRM_IN,
  input wire [2:0] REQ_OPC2_IN,
  // Response
  input wire RESP_DONE_OUT,
  input wire RESP_UNDEF_OUT,
  input wire [31:0] RESP_RDATA_OUT,
  input wire BP_INV_DONE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================================
  // Request classes
  wire idr = REQ_VALID_IN && REQ_OPC1_IN == 3'h0 && REQ_CRN_IN == 4'h0 && REQ_CRM_IN == 4'h1
    && REQ_OPC2_IN >= 3'h5;
  wire bpr = REQ_VALID_IN && REQ_OPC1_IN == 3'h0 && REQ_CRN_IN == 4'h7 && REQ_CRM_IN == 4'h5
    && REQ_OPC2_IN >= 3'h6;
  wire rd = idr && REQ_PRIV_IN && !REQ_WRITE_IN;
  wire inv = bpr && REQ_PRIV_IN && REQ_WRITE_IN;
  // ==========================================================
  // Properties
  property p_one; rd && REQ_OPC2_IN == 3'h5 |=> RESP_DONE_OUT && RESP_RDATA_OUT == 32'h0;
  endproperty
  a_one: assert property (p_one) else $error("first register wrong");
  property p_two; rd && REQ_OPC2_IN == 3'h6 |=> RESP_DONE_OUT && RESP_RDATA_OUT == 32'h01200000;
  endproperty
  a_two: assert property (p_two) else $error("second register wrong");
  property p_three; rd && REQ_OPC2_IN == 3'h7 |=> RESP_RDATA_OUT == 32'h00000211;
  endproperty
  a_three: assert property (p_three) else $error("third register wrong");
  property p_refuse; (idr || bpr) && !(rd || inv) |=> RESP_UNDEF_OUT && !RESP_DONE_OUT
    && RESP_RDATA_OUT == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal wrong");
  property p_inv; inv |=> BP_INV_DONE_OUT && RESP_DONE_OUT && RESP_RDATA_OUT == 32'h0;
  endproperty
  a_inv: assert property (p_inv) else $error("invalidate wrong");
  property p_quiet; !(idr || bpr) |=> !RESP_DONE_OUT && !RESP_UNDEF_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious response");
  property p_cause; RESP_DONE_OUT |-> $past(rd || inv);
  endproperty
  a_cause: assert property (p_cause) else $error("done without request");
  property p_data; RESP_RDATA_OUT != 32'h0 |-> RESP_DONE_OUT && !BP_INV_DONE_OUT;
  endproperty
  a_data: assert property (p_data) else $error("stray read data");
endmodule // mmfid_regs_chk

bind mmfid_regs mmfid_regs_chk i_mmfid_regs_chk (.CLOCK_IN, .SYS_RST_IN, .REQ_VALID_IN,
  .REQ_WRITE_IN, .REQ_PRIV_IN, .REQ_OPC1_IN, .REQ_CRN_IN, .REQ_CRM_IN, .REQ_OPC2_IN,
  .RESP_DONE_OUT, .RESP_UNDEF_OUT, .RESP_RDATA_OUT, .BP_INV_DONE_OUT);

// >>> verif/tb_top.sv
// Self-checking testbench for the feature identification bank
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg vld = 1'b0, wr = 1'b0, pr = 1'b0;
  reg [2:0] o1 = 3'h0, o2 = 3'h0;
  reg [3:0] n = 4'h0, m = 4'h0;
  wire dn, ud, bp;
  wire [31:0] rdat;
  integer num_errors = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  mmfid_regs i_mmfid_regs (.CLOCK_IN(clk), .SYS_RST_IN(rst), .REQ_VALID_IN(vld),
    .REQ_WRITE_IN(wr), .REQ_PRIV_IN(pr), .REQ_OPC1_IN(o1), .REQ_CRN_IN(n), .REQ_CRM_IN(m),
    .REQ_OPC2_IN(o2), .RESP_DONE_OUT(dn), .RESP_UNDEF_OUT(ud), .RESP_RDATA_OUT(rdat),
    .BP_INV_DONE_OUT(bp));
  task tally_and_finish;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string nm, input logic [34:0] e, input logic [34:0] g);
    cmp_count++;
    if (e !== g) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One request, response checked one cycle later as {done, undef, bp, data}
  task rq(input logic w, p, input logic [2:0] a, input logic [3:0] c, d,
    input logic [2:0] b, input logic [34:0] ex);
    vld = 1'b1;
    wr = w;
    pr = p;
    o1 = a;
    n = c;
    m = d;
    o2 = b;
    @(posedge clk);
    #1;
    cmp("response", ex, {dn, ud, bp, rdat});
  endtask
  // Idle cycle; every output must have dropped back
  task idle;
    vld = 1'b0;
    @(posedge clk);
    #1;
    cmp("idle", 35'h0, {dn, ud, bp, rdat});
  endtask
  task t_reads;
    rq(0, 1, 0, 0, 1, 5, {3'b100, 32'h00000000});
    rq(0, 1, 0, 0, 1, 6, {3'b100, 32'h01200000});
    rq(0, 1, 0, 0, 1, 7, {3'b100, 32'h00000211});
    idle();
  endtask
  task t_refuse;
    rq(0, 0, 0, 0, 1, 7, {3'b010, 32'h0});
    rq(1, 1, 0, 0, 1, 6, {3'b010, 32'h0});
    rq(0, 1, 0, 0, 1, 6, {3'b100, 32'h01200000});
    rq(1, 0, 0, 7, 5, 7, {3'b010, 32'h0});
    idle();
  endtask
  task t_bp;
    rq(1, 1, 0, 7, 5, 6, {3'b101, 32'h0});
    rq(1, 1, 0, 7, 5, 7, {3'b101, 32'h0});
    rq(0, 1, 0, 7, 5, 6, {3'b010, 32'h0});
    idle();
  endtask
  task t_other;
    rq(0, 1, 0, 0, 1, 4, 35'h0);
    rq(0, 1, 1, 0, 1, 5, 35'h0);
    idle();
  endtask
  // Mid-run reset: a request under reset is dropped, the first one after answers at once
  task t_reset;
    rst = 1'b1;
    rq(0, 1, 0, 0, 1, 6, 35'h0);
    rst = 1'b0;
    rq(0, 1, 0, 0, 1, 7, {3'b100, 32'h00000211});
    idle();
  endtask
  // Hang guard, well above the few dozen cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    idle();
    t_reads();
    t_refuse();
    t_bp();
    t_other();
    t_reset();
    tally_and_finish();
  end
endmodule // tb_top
